// File: src/card_port_pkg.sv
package card_port_pkg;

    // ==========================================================
    // Attribute space map
    // ==========================================================
    localparam logic [10:0] CFG_BASE_ADDR     = 11'h200;  // Configuration register base
    localparam logic [10:0] PIN_REPL_ADDR     = 11'h204;  // pin_replacement_status
    localparam logic [10:0] SOCKET_COPY_ADDR  = 11'h206;  // socket_copy_config
    localparam int          ADDR_A9           = 9;        // Config/information select
    localparam int          ADDR_A10          = 10;       // Must be low in attribute space

    // ==========================================================
    // Pin replacement field layout
    // ==========================================================
    localparam int          PR_READY_CHG_BIT  = 5;        // ready_changed_flag
    localparam int          PR_WP_CHG_BIT     = 4;        // wp_changed_flag
    localparam int          PR_READY_BIT      = 1;        // Ready state / ready_change_mask
    localparam int          PR_WP_BIT         = 0;        // wp_state_bit / wp_change_mask
    localparam logic [7:0]  PR_RESET_VALUE    = 8'h0c;    // Value after reset
    localparam logic [7:0]  PR_FIXED_ONES     = 8'h0c;    // Bits 3 and 2 read as one

    // ==========================================================
    // Socket and copy field layout
    // ==========================================================
    localparam int          SC_DRIVE_BIT      = 4;        // Drive number bit
    localparam logic        SC_DRIVE_RESET    = 1'b0;     // Drive number after reset

    // ==========================================================
    // Configuration index values
    // ==========================================================
    localparam logic [5:0]  CFG_IDX_MEMORY    = 6'h00;    // Memory mode
    localparam logic [5:0]  CFG_IDX_CONTIG    = 6'h01;    // Contiguous I/O
    localparam logic [5:0]  CFG_IDX_PRIMARY   = 6'h02;    // Primary I/O
    localparam logic [5:0]  CFG_IDX_SECOND    = 6'h03;    // Secondary I/O

    // ==========================================================
    // Synchronised pin vector layout
    // ==========================================================
    localparam int          PIN_CTRL_W        = 7;        // Strobes and selects
    localparam int          PIN_VEC_W         = PIN_CTRL_W + 11 + 16;

endpackage

// File: src/card_port.sv
`timescale 1ns/1ps
// Contract
// - Ready toggle sets ready-changed flag, sticky
// - Write-protect toggle sets wp-changed flag
// - Ready-changed flag written only when mask set
// - Wp-changed flag written only when mask set
// - Ready bit shows ready, or irq in I/O
// - Write-protect state bit always reads zero
// - Pin register resets 0Ch, fixed bits unwritable
// - Socket register bit 4 holds drive number
// - Socket number bits ignored, read zero
// - Attribute accesses byte-wide at even addresses
// - Config registers at 204h and 206h
// - No attribute response in disk-style mode
// - Attribute reads drive low lane only
// - A9 low information read-only, high config
// - Assert 16-bit indication on every I/O port
// - I/O lane steering by enables and A0
// - Common memory uses same lane steering
// - Changed summary and status-change pin
// - Configuration index selects memory or I/O
module card_port
    import card_port_pkg::*;
#(
    parameter int SYNC_DEPTH = 3                    // Pin synchroniser depth
) (
    input  wire logic        clk_sys,               // Core clock
    input  wire logic        reset,                 // Synchronous, active high
    input  wire logic        ce1_n,                 // Even card enable
    input  wire logic        ce2_n,                 // Odd card enable
    input  wire logic        reg_n,                 // Attribute / I/O space select
    input  wire logic        oe_n,                  // Memory read strobe
    input  wire logic        we_n,                  // Memory write strobe
    input  wire logic        iord_n,                // I/O read strobe
    input  wire logic        iowr_n,                // I/O write strobe
    input  wire logic [10:0] addr,                  // Host address
    input  wire logic [15:0] data_in,               // Host data bus, input side
    output logic      [15:0] data_out,              // Host data bus, output side
    output logic             data_oe_lo,            // Drive enable, D7..D0
    output logic             data_oe_hi,            // Drive enable, D15..D8
    output logic             iois16_n,              // 16-bit port indication
    output logic             stschg_n,              // Status change pin
    input  wire logic        ready_raw,             // Core ready condition
    input  wire logic        irq_raw,               // Core interrupt request
    input  wire logic        wp_state_raw,          // Core write-protect level
    input  wire logic        disk_style_mode,       // Disk-style mode active
    input  wire logic [5:0]  config_index,          // From option register
    input  wire logic        change_signal_enable,  // From status register
    input  wire logic [7:0]  cis_rd_data,           // Information structure byte
    input  wire logic [15:0] core_rd_data,          // Odd byte high, even byte low
    output logic             status_changed,        // Changed summary bit
    output logic             drive_number,          // Drive number for core
    output logic             xfer_rd,               // Core read pulse
    output logic             xfer_wr,               // Core write pulse
    output logic             xfer_io,               // Transfer was I/O
    output logic             xfer_even,             // Even byte in transfer
    output logic             xfer_odd,              // Odd byte in transfer
    output logic      [10:0] xfer_addr,             // Transfer address
    output logic      [15:0] xfer_wr_data           // Odd byte high, even byte low
);
    import card_port_pkg::*;

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (SYNC_DEPTH < 3) begin : g_bad_depth
        $error("SYNC_DEPTH below three cannot filter pins");
    end

    // ==========================================================
    // Pin synchroniser
    // ==========================================================
    logic [PIN_VEC_W-1:0] pin_raw;                  // Gathered pin inputs
    logic [PIN_VEC_W-1:0] sync_q [SYNC_DEPTH];      // Synchroniser chain
    logic [PIN_VEC_W-1:0] pin_q;                    // Filtered pin state
    logic [PIN_VEC_W-1:0] agree;                    // Last two stages equal

    assign pin_raw = {data_in, addr, iowr_n, iord_n, we_n, oe_n, reg_n, ce2_n, ce1_n};

    // Chain shifts every cycle; stage zero is read only by stage one
    always_ff @(posedge clk_sys) begin
        sync_q[0] <= pin_raw;
        for (int i = 1; i < SYNC_DEPTH; i++) begin
            sync_q[i] <= sync_q[i-1];
        end
    end

    // A change counts once the last two stages agree, per bit
    assign agree = ~(sync_q[SYNC_DEPTH-2] ^ sync_q[SYNC_DEPTH-1]);

    generate
        for (genvar b = 0; b < PIN_VEC_W; b++) begin : g_filter
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    pin_q[b] <= (b < PIN_CTRL_W) ? 1'b1 : 1'b0;  // Strobes idle high
                end else if (agree[b]) begin
                    pin_q[b] <= sync_q[SYNC_DEPTH-1][b];
                end
            end
        end
    endgenerate

    // Named views of the filtered pins
    wire        s_ce1_n  = pin_q[0];
    wire        s_ce2_n  = pin_q[1];
    wire        s_reg_n  = pin_q[2];
    wire        s_oe_n   = pin_q[3];
    wire        s_we_n   = pin_q[4];
    wire        s_iord_n = pin_q[5];
    wire        s_iowr_n = pin_q[6];
    wire [10:0] s_addr   = pin_q[PIN_CTRL_W +: 11];
    wire [15:0] s_data   = pin_q[PIN_CTRL_W+11 +: 16];

    // ==========================================================
    // Mode and space decode
    // ==========================================================
    wire io_mode   = (config_index == CFG_IDX_CONTIG) || (config_index == CFG_IDX_PRIMARY) ||
                     (config_index == CFG_IDX_SECOND);
    wire card_sel  = !s_ce1_n || !s_ce2_n;
    // Attribute space: even byte only, low enable, not in disk-style mode
    wire attr_sel  = !s_reg_n && !s_ce1_n && !s_addr[0] && !disk_style_mode;
    wire attr_cfg  = attr_sel && !s_addr[ADDR_A10] && s_addr[ADDR_A9];
    wire attr_cis  = attr_sel && !s_addr[ADDR_A10] && !s_addr[ADDR_A9];
    wire attr_rd   = (attr_cfg || attr_cis) && !s_oe_n && s_we_n;
    wire io_sel    = !s_reg_n && card_sel && io_mode && !disk_style_mode;
    wire mem_sel   = s_reg_n && card_sel && !disk_style_mode;
    wire io_rd     = io_sel && !s_iord_n && s_iowr_n;
    wire mem_rd    = mem_sel && !s_oe_n && s_we_n;

    // Lane steering shared by I/O and common memory
    wire even_lane = !s_ce1_n && (!s_ce2_n || !s_addr[0]);
    wire odd_low   = !s_ce1_n && s_ce2_n && s_addr[0];
    wire odd_high  = !s_ce2_n;

    // ==========================================================
    // Write strobe trailing edge
    // ==========================================================
    logic we_prev_q;                                // Combined write strobe, last cycle
    logic attr_wr_q;                                // Attribute write in progress
    logic data_wr_q;                                // Data write in progress
    logic io_wr_q;                                  // Data write was I/O
    logic [10:0] wr_addr_q;                         // Address held during strobe
    logic [15:0] wr_data_q;                         // Data held during strobe
    logic wr_even_q;                                // Even lane held during strobe
    logic wr_odd_q;                                 // Odd lane held during strobe
    logic wr_odd_low_q;                             // Odd byte rode the low lane

    wire we_now    = (!s_we_n && s_oe_n && (attr_cfg || mem_sel)) ||
                     (io_sel && !s_iowr_n && s_iord_n);
    // Disk-style mode cancels a write still pending, so nothing commits there
    wire wr_end    = we_prev_q && !we_now && !disk_style_mode;

    // Latch cycle details while the strobe is low; commit on its release
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            we_prev_q <= 1'b0;
            attr_wr_q <= 1'b0;
            data_wr_q <= 1'b0;
            io_wr_q   <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
            wr_even_q <= 1'b0;
            wr_odd_q  <= 1'b0;
            wr_odd_low_q <= 1'b0;
        end else begin
            we_prev_q <= we_now;
            if (we_now) begin
                attr_wr_q <= attr_cfg;              // Writes to information area dropped
                data_wr_q <= !attr_cfg;
                io_wr_q   <= io_sel;
                wr_addr_q <= s_addr;
                wr_data_q <= s_data;
                wr_even_q <= even_lane;
                wr_odd_q  <= odd_low || odd_high;
                wr_odd_low_q <= odd_low;
            end
        end
    end

    // Odd byte arriving on the low lane moves to the odd half; the high lane is don't-care then
    wire [15:0] wr_steered = wr_odd_low_q ? {wr_data_q[7:0], 8'h00} : wr_data_q;

    // ==========================================================
    // Pin replacement register
    // ==========================================================
    logic ready_changed_flag_q;                     // Sticky ready change
    logic wp_changed_flag_q;                        // Sticky write-protect change
    logic ready_prev_q;                             // Ready bit, last cycle
    logic wp_prev_q;                                // Write-protect bit, last cycle

    wire ready_state   = io_mode ? irq_raw : ready_raw;
    wire wp_state_bit  = 1'b0;
    wire ready_toggle  = ready_state != ready_prev_q;
    wire wp_toggle     = wp_state_bit != wp_prev_q;
    wire pr_write      = wr_end && attr_wr_q && (wr_addr_q == PIN_REPL_ADDR);
    wire sc_write      = wr_end && attr_wr_q && (wr_addr_q == SOCKET_COPY_ADDR);
    wire ready_change_mask = wr_data_q[PR_READY_BIT];
    wire wp_change_mask    = wr_data_q[PR_WP_BIT];
    // Unused input kept for a core that does report protection
    wire unused_wp = wp_state_raw;

    // Toggle sets beat a host clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ready_changed_flag_q <= PR_RESET_VALUE[PR_READY_CHG_BIT];
            wp_changed_flag_q    <= PR_RESET_VALUE[PR_WP_CHG_BIT];
            ready_prev_q         <= 1'b0;
            wp_prev_q            <= 1'b0;
        end else begin
            ready_prev_q <= ready_state;
            wp_prev_q    <= wp_state_bit;
            if (ready_toggle) begin
                ready_changed_flag_q <= 1'b1;
            end else if (pr_write && ready_change_mask) begin
                ready_changed_flag_q <= wr_data_q[PR_READY_CHG_BIT];
            end
            if (wp_toggle) begin
                wp_changed_flag_q <= 1'b1;
            end else if (pr_write && wp_change_mask) begin
                wp_changed_flag_q <= wr_data_q[PR_WP_CHG_BIT];
            end
        end
    end

    // Fixed bits come from constants; writes cannot reach them
    wire [7:0] pr_read = PR_FIXED_ONES
                       | ({7'h00, ready_changed_flag_q} << PR_READY_CHG_BIT)
                       | ({7'h00, wp_changed_flag_q} << PR_WP_CHG_BIT)
                       | ({7'h00, ready_state} << PR_READY_BIT)
                       | ({7'h00, wp_state_bit} << PR_WP_BIT);

    // ==========================================================
    // Socket and copy register
    // ==========================================================
    logic drive_q;                                  // Drive number bit

    // Only the drive bit is stored; socket bits are dropped
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            drive_q <= SC_DRIVE_RESET;
        end else if (sc_write) begin
            drive_q <= wr_data_q[SC_DRIVE_BIT];
        end
    end

    wire [7:0] sc_read = {7'h00, drive_q} << SC_DRIVE_BIT;

    // ==========================================================
    // Read data and lane drive
    // ==========================================================
    // Offsets 200h and 202h belong to another block and read zero here
    wire [7:0] cfg_read = (s_addr == PIN_REPL_ADDR)    ? pr_read :
                          (s_addr == SOCKET_COPY_ADDR) ? sc_read : 8'h00;
    wire [7:0] attr_byte = attr_cfg ? cfg_read : cis_rd_data;
    wire       data_rd   = io_rd || mem_rd;
    wire [7:0] low_byte  = odd_low ? core_rd_data[15:8] : core_rd_data[7:0];
    wire [15:0] rd_word  = attr_rd ? {8'h00, attr_byte} : {core_rd_data[15:8], low_byte};
    wire       oe_lo_d   = attr_rd || (data_rd && (even_lane || odd_low));
    wire       oe_hi_d   = !attr_rd && data_rd && odd_high;
    wire       any_chg   = ready_changed_flag_q || wp_changed_flag_q;

    // Registered bus drive, one cycle behind the filtered pins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            data_out       <= '0;
            data_oe_lo     <= 1'b0;
            data_oe_hi     <= 1'b0;
            iois16_n       <= 1'b1;
            stschg_n       <= 1'b1;
            status_changed <= 1'b0;
            drive_number   <= SC_DRIVE_RESET;
        end else begin
            data_out       <= rd_word;
            data_oe_lo     <= oe_lo_d;
            data_oe_hi     <= oe_hi_d;
            iois16_n       <= !io_sel;
            stschg_n       <= !(io_mode && change_signal_enable && any_chg);
            status_changed <= any_chg;
            drive_number   <= drive_q;
        end
    end

    // ==========================================================
    // Core transfer strobes
    // ==========================================================
    logic rd_prev_q;                                // Data read seen last cycle

    // One pulse per read start and per committed data write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_prev_q    <= 1'b0;
            xfer_rd      <= 1'b0;
            xfer_wr      <= 1'b0;
            xfer_io      <= 1'b0;
            xfer_even    <= 1'b0;
            xfer_odd     <= 1'b0;
            xfer_addr    <= '0;
            xfer_wr_data <= '0;
        end else begin
            rd_prev_q <= data_rd;
            xfer_rd   <= data_rd && !rd_prev_q;
            xfer_wr   <= wr_end && data_wr_q;
            if (data_rd && !rd_prev_q) begin
                xfer_io   <= io_sel;
                xfer_even <= even_lane;
                xfer_odd  <= odd_low || odd_high;
                xfer_addr <= s_addr;
            end else if (wr_end && data_wr_q) begin
                xfer_io      <= io_wr_q;
                xfer_even    <= wr_even_q;
                xfer_odd     <= wr_odd_q;
                xfer_addr    <= wr_addr_q;
                xfer_wr_data <= wr_steered;
            end
        end
    end

endmodule

// File: sim/card_port_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the card-side decoder
module card_port_asserts
    import card_port_pkg::*;
#(
    parameter int SYNC_DEPTH = 3                    // Matches the design's synchroniser
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        ce2_n,
    input  wire logic        reg_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        iord_n,
    input  wire logic        data_oe_lo,
    input  wire logic        data_oe_hi,
    input  wire logic        iois16_n,
    input  wire logic        stschg_n,
    input  wire logic        ready_raw,
    input  wire logic        disk_style_mode,
    input  wire logic [5:0]  config_index,
    input  wire logic        change_signal_enable,
    input  wire logic        status_changed,
    input  wire logic        xfer_rd,
    input  wire logic        xfer_wr
);
    import card_port_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // Ready toggle in memory mode, then the summary rises soon after
    sequence s_ready_toggle;
        $changed(ready_raw) && config_index == CFG_IDX_MEMORY;
    endsequence
    sequence s_summary_up;
        ##[1:6] status_changed;
    endsequence

    a_ready_sets_flag: assert property (s_ready_toggle |-> s_summary_up)
        else $error("ready toggle did not raise the summary");
    a_flag_sticky_write: assert property ($fell(status_changed) |-> !$past(we_n, 6) || !$past(we_n, 7))
        else $error("summary fell without a host write");
    a_stschg_cause: assert property (!stschg_n |->
        status_changed && $past(change_signal_enable) && $past(config_index) != CFG_IDX_MEMORY)
        else $error("status change pin low without cause");
    a_iois16_io_only: assert property (!iois16_n |->
        $past(config_index) != CFG_IDX_MEMORY && !$past(reg_n, SYNC_DEPTH + 2))
        else $error("16-bit indication outside an I/O cycle");
    a_disk_mode_quiet: assert property (disk_style_mode && $past(disk_style_mode) |->
        !data_oe_lo && !data_oe_hi && !xfer_rd && !xfer_wr)
        else $error("response while in disk-style mode");
    a_high_lane_ce2: assert property (data_oe_hi |-> !$past(ce2_n, SYNC_DEPTH + 2))
        else $error("high lane driven without odd enable");
    a_drive_needs_read: assert property ($rose(data_oe_lo) |-> !$past(oe_n, 2) || !$past(iord_n, 2))
        else $error("low lane driven without a read strobe");
    a_write_pulse_one: assert property (xfer_wr |=> !xfer_wr)
        else $error("write pulse longer than one cycle");
    a_read_pulse_one: assert property (xfer_rd |=> !xfer_rd)
        else $error("read pulse longer than one cycle");
endmodule

bind card_port card_port_asserts #(.SYNC_DEPTH(SYNC_DEPTH)) u_asserts (.clk_sys, .reset, .ce2_n, .reg_n,
    .oe_n, .we_n, .iord_n, .data_oe_lo, .data_oe_hi, .iois16_n, .stschg_n, .ready_raw, .disk_style_mode,
    .config_index, .change_signal_enable, .status_changed, .xfer_rd, .xfer_wr);

// File: sim/host_socket_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host socket controller: one cycle per call
module host_socket_model (
    input  wire logic        clk_sys,
    output logic             ce1_n,
    output logic             ce2_n,
    output logic             reg_n,
    output logic             oe_n,
    output logic             we_n,
    output logic             iord_n,
    output logic             iowr_n,
    output logic      [10:0] addr,
    output logic      [15:0] data_in,
    input  wire logic [15:0] data_out,
    input  wire logic        data_oe_lo,
    input  wire logic        data_oe_hi,
    input  wire logic        iois16_n
);
    logic [15:0] q;                                 // Last read data
    logic        lo, hi, io16;                      // Lanes and width seen

    // Idle socket at time zero
    initial begin
        {ce2_n, ce1_n, reg_n, oe_n, we_n, iord_n, iowr_n} = 7'h7f;
        addr = 11'h000;
        data_in = 16'hffff;
    end

    // Kind k is {io, write, reg_n}; ce is {ce2_n, ce1_n}
    task automatic xfer(input logic [2:0] k, input logic [1:0] ce, input logic [10:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        {ce2_n, ce1_n} = ce;
        reg_n = k[0];
        addr = a;
        data_in = d;
        {oe_n, we_n} = {k[2] | k[1], k[2] | !k[1]};
        {iord_n, iowr_n} = {!k[2] | k[1], !k[2] | !k[1]};
        // Strobe held long enough for the pin filter
        repeat (7) @(negedge clk_sys);
        q = data_out;
        {hi, lo, io16} = {data_oe_hi, data_oe_lo, !iois16_n};
        @(negedge clk_sys);
        {oe_n, we_n, iord_n, iowr_n} = 4'hf;
        repeat (6) @(negedge clk_sys);
        {ce2_n, ce1_n} = 2'h3;
        data_in = ~d;                               // Released bus does not keep its value
        repeat (6) @(negedge clk_sys);
    endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Testbench: register, memory and I/O cycles
module tb_top;
    import card_port_pkg::*;
    logic        clk_sys, reset, ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n;
    logic        data_oe_lo, data_oe_hi, iois16_n, stschg_n, ready_raw, irq_raw, wp_state_raw;
    logic        disk_style_mode, change_signal_enable, status_changed, drive_number;
    logic        xfer_rd, xfer_wr, xfer_io, xfer_even, xfer_odd;
    logic [5:0]  config_index;
    logic [7:0]  cis_rd_data;
    logic [10:0] addr, xfer_addr;
    logic [15:0] data_in, data_out, core_rd_data, xfer_wr_data;
    int          n_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;

    card_port #(.SYNC_DEPTH(3)) i_dut (.clk_sys, .reset, .ce1_n, .ce2_n, .reg_n, .oe_n, .we_n, .iord_n,
        .iowr_n, .addr, .data_in, .data_out, .data_oe_lo, .data_oe_hi, .iois16_n, .stschg_n, .ready_raw,
        .irq_raw, .wp_state_raw, .disk_style_mode, .config_index, .change_signal_enable, .cis_rd_data,
        .core_rd_data, .status_changed, .drive_number, .xfer_rd, .xfer_wr, .xfer_io, .xfer_even, .xfer_odd,
        .xfer_addr, .xfer_wr_data);
    host_socket_model i_host (.clk_sys, .ce1_n, .ce2_n, .reg_n, .oe_n, .we_n, .iord_n, .iowr_n, .addr,
        .data_in, .data_out, .data_oe_lo, .data_oe_hi, .iois16_n);

    // 100 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Hang guard, well above the expected run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read cycle; data compared only on lanes expected to drive
    task automatic rd(input logic [2:0] k, input logic [1:0] ce, input logic [10:0] a,
                      input logic [1:0] ln, input logic [15:0] exp);
        logic [15:0] m;
        m = {{8{ln[1]}}, {8{ln[0]}}};
        i_host.xfer(k, ce, a, 16'h0000);
        chk({14'h0, i_host.hi, i_host.lo}, {14'h0, ln});
        chk(i_host.q & m, exp & m);
    endtask

    // Attribute byte write with the odd enable idle
    task automatic awr(input logic [10:0] a, input logic [7:0] d);
        i_host.xfer(3'h2, 2'h2, a, {8'h00, d});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {reset, ready_raw, irq_raw, wp_state_raw, disk_style_mode, change_signal_enable} = 6'h20;
        config_index = CFG_IDX_MEMORY;
        cis_rd_data = 8'ha5;
        core_rd_data = 16'hbeef;
        repeat (3) @(negedge clk_sys);
        reset = 1'h0;
        rd(3'h0, 2'h2, 11'h204, 2'h1, 16'h000c);
        rd(3'h0, 2'h2, 11'h206, 2'h1, 16'h0000);
        awr(11'h206, 8'hff);
        rd(3'h0, 2'h2, 11'h206, 2'h1, 16'h0010);
        chk({15'h0, drive_number}, 16'h0001);
        awr(11'h204, 8'hff);
        rd(3'h0, 2'h2, 11'h204, 2'h1, 16'h003c);
        chk({15'h0, status_changed}, 16'h0001);
        awr(11'h204, 8'h30);
        rd(3'h0, 2'h2, 11'h204, 2'h1, 16'h003c);
        awr(11'h204, 8'h03);
        rd(3'h0, 2'h2, 11'h204, 2'h1, 16'h000c);
        chk({15'h0, status_changed}, 16'h0000);
        ready_raw = 1'h1;
        rd(3'h0, 2'h0, 11'h204, 2'h1, 16'h002e);
        awr(11'h204, 8'h02);
        rd(3'h0, 2'h2, 11'h204, 2'h1, 16'h000e);
        awr(11'h004, 8'h77);
        chk({5'h0, xfer_addr}, 16'h0000);
        rd(3'h0, 2'h2, 11'h004, 2'h1, 16'h00a5);
        rd(3'h0, 2'h2, 11'h205, 2'h0, 16'h0000);
        rd(3'h0, 2'h2, 11'h604, 2'h0, 16'h0000);
        rd(3'h1, 2'h0, 11'h400, 2'h3, 16'hbeef);
        chk({15'h0, i_host.io16}, 16'h0000);
        rd(3'h1, 2'h2, 11'h401, 2'h1, 16'h00be);
        rd(3'h1, 2'h1, 11'h400, 2'h2, 16'hbe00);
        i_host.xfer(3'h3, 2'h0, 11'h010, 16'h1234);
        chk({13'h0, xfer_io, xfer_odd, xfer_even}, 16'h0003);
        chk(xfer_wr_data, 16'h1234);
        irq_raw = 1'h1;
        for (int i = 1; i <= 3; i++) begin
            config_index = 6'(i);
            rd(3'h4, 2'h0, 11'h1f0, 2'h3, 16'hbeef);
            if (!i_host.io16) rd(3'h4, 2'h2, 11'h1f1, 2'h1, 16'h00be);
            chk({15'h0, i_host.io16}, 16'h0001);
        end
        rd(3'h4, 2'h1, 11'h1f1, 2'h2, 16'hbe00);
        i_host.xfer(3'h6, 2'h2, 11'h1f1, 16'haa55);
        chk({5'h0, xfer_io, xfer_odd, xfer_even, xfer_wr_data[15:8]}, {5'h0, 3'h6, 8'h55});
        chk({5'h0, xfer_addr}, 16'h01f1);
        rd(3'h0, 2'h2, 11'h204, 2'h1, 16'h000e);
        irq_raw = 1'h0;
        change_signal_enable = 1'h1;
        rd(3'h0, 2'h2, 11'h204, 2'h1, 16'h002c);
        chk({15'h0, stschg_n}, 16'h0000);
        change_signal_enable = 1'h0;
        repeat (3) @(negedge clk_sys);
        chk({15'h0, stschg_n}, 16'h0001);
        disk_style_mode = 1'h1;
        rd(3'h0, 2'h2, 11'h204, 2'h0, 16'h0000);
        print_verdict();
    end
endmodule
